// ==== design/usbr_endpoint_regs.sv ====
`timescale 1ns/10ps
// Behaviour
// - Auto status-out set: hardware answers the control read OUT status stage.
// - Endpoint 2 enable gates its transfers; reset clears it.
// - Endpoint 1 enable gates its transfers; reset clears it.
// - Endpoint 2 force-stall makes it answer STALL; reset clears it.
// - Endpoint 1 force-stall makes it answer STALL; reset clears it.
// - Expected toggle (0 DATA0, 1 DATA1) is compared with endpoint 0 data PID.
// - Setup-detect bit sets on a SETUP token.
// - IN-detect bit sets on an IN token.
// - OUT-detect bit sets on an OUT token.
// - Four-bit field reports bytes in last endpoint 0 DATA packet whose toggle matched, auto status-out stages excepted.
// - Endpoint 0 received bytes are read through an 8-bit register.
// - Endpoint 0 transmit bytes are written through an 8-bit register.
// - Endpoint 1 transmit bytes are written through an 8-bit register.
// - Logic clock is MCU clock over two, over prescaler plus one.
// - Endpoint 1/2 IN gets NAK when transmit disabled or transmit-done set.
module usbr_endpoint_regs
   import usbr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Token and data packets from the serial engine
   input wire logic tok_valid,
   input wire logic [3:0] tok_pid,
   input wire logic [6:0] tok_addr,
   input wire logic [3:0] tok_endp,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_pkt_end,
   input wire logic [3:0] rx_pid,
   input wire logic tx_ack,
   // Bus events
   input wire logic bus_reset,
   input wire logic bus_suspend,
   input wire logic bus_eop,
   input wire logic bus_resume,
   // Answers to the serial engine
   output logic usb_clk_en,
   output logic resp_valid,
   output usbr_resp_t resp_kind,
   output logic [3:0] resp_pid,
   output logic [3:0] resp_len,
   output logic [7:0] tx_byte,
   output logic force_resume
);
   usbr_clk_if clk_link ();

   logic [7:0] usb_clock_divider, ep1_tx_data, ep0_tx_data, usb_interrupt_flags;
   logic [7:0] usb_interrupt_enables, ep0_tx_control, ep12_tx_control, endpoint_enable_control;
   logic [7:0] ep0_rx_status, function_address, ep0_rx_data, flag_set, next_flags;
   logic [3:0] rx_count;
   logic ctl_read, ctl_setup, auto_status, tx_ep12;
   usbr_state_t state;
   logic tok_hit, tok_ep0, tok_ep12, ep12_enabled, ep12_stalled, toggle_match, data_end_ep0;

   // Register write decode, shared by every writable register
   function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] offset, input logic wr);
      wr_hit = wr && (addr == offset);
   endfunction : wr_hit

   usbr_prescaler u_prescaler (
      .sys_clk (sys_clk),
      .rst_b (rst_b),
      .clk_port (clk_link.divider)
   );

   assign clk_link.divide_value = usb_clock_divider;

   // Token qualification: address match and function enable
   assign tok_hit = tok_valid && function_address[BIT_USB_FUNCTION_ENABLE]
      && (tok_addr == function_address[6:0]);
   assign tok_ep0 = tok_hit && (tok_endp == 4'h0);
   assign tok_ep12 = tok_hit && (tok_endp == 4'h1 || tok_endp == 4'h2);
   // Enable and stall of the token's endpoint
   assign ep12_enabled = (tok_endp == 4'h2) ? endpoint_enable_control[BIT_ENDPOINT2_ENABLE]
      : endpoint_enable_control[BIT_ENDPOINT1_ENABLE];
   assign ep12_stalled = (tok_endp == 4'h2) ? endpoint_enable_control[BIT_ENDPOINT2_FORCE_STALL]
      : endpoint_enable_control[BIT_ENDPOINT1_FORCE_STALL];
   // Received data PID against the expected toggle
   assign toggle_match = ep0_rx_status[BIT_EP0_EXPECTED_TOGGLE] ? (rx_pid == PID_DATA1)
      : (rx_pid == PID_DATA0);
   assign data_end_ep0 = (state == ST_RX_DATA) && rx_pkt_end;

   // Hardware events that set sticky flags
   always_comb
   begin
      flag_set = 8'h00;
      flag_set[BIT_SUSPEND_FLAG] = bus_suspend;
      flag_set[BIT_BUS_RESET_FLAG] = bus_reset;
      flag_set[BIT_EOP_FLAG] = bus_eop;
      flag_set[BIT_RESUME_FLAG] = bus_resume;
      flag_set[BIT_EP0_TX_DONE_FLAG] = (state == ST_TX_WAIT) && tx_ack && !tx_ep12;
      flag_set[BIT_EP12_TX_DONE_FLAG] = (state == ST_TX_WAIT) && tx_ack && tx_ep12;
      flag_set[BIT_EP0_RX_DONE_FLAG] = data_end_ep0 && toggle_match && !auto_status;
   end

   // Software clears a flag by writing 0; an event in the same cycle still sets it
   always_comb
   begin
      next_flags = usb_interrupt_flags;
      if (wr_hit(sfr_addr, ADDR_INT_FLAGS, sfr_wr))
         next_flags = usb_interrupt_flags & sfr_wdata;
      next_flags = next_flags | flag_set;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         usb_interrupt_flags <= REG_RESET;
      else
         usb_interrupt_flags <= next_flags;
   end

   // Plain read/write registers
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         usb_clock_divider <= REG_RESET;
         ep1_tx_data <= REG_RESET;
         ep0_tx_data <= REG_RESET;
         usb_interrupt_enables <= REG_RESET;
         ep0_tx_control <= REG_RESET;
         ep12_tx_control <= REG_RESET;
         endpoint_enable_control <= REG_RESET;
         function_address <= REG_RESET;
      end
      else
      begin
         // Prescaler; only 0, 1 or 2 give 6 MHz from the supported clocks
         if (wr_hit(sfr_addr, ADDR_CLOCK_DIVIDER, sfr_wr))
            usb_clock_divider <= sfr_wdata;
         if (wr_hit(sfr_addr, ADDR_EP1_TX_DATA, sfr_wr))
            ep1_tx_data <= sfr_wdata;
         if (wr_hit(sfr_addr, ADDR_EP0_TX_DATA, sfr_wr))
            ep0_tx_data <= sfr_wdata;
         if (wr_hit(sfr_addr, ADDR_INT_ENABLES, sfr_wr))
            usb_interrupt_enables <= sfr_wdata;
         if (wr_hit(sfr_addr, ADDR_EP0_TX_CONTROL, sfr_wr))
            ep0_tx_control <= sfr_wdata;
         if (wr_hit(sfr_addr, ADDR_EP12_TX_CONTROL, sfr_wr))
            ep12_tx_control <= sfr_wdata;
         // Reserved bits 7..5 are not stored and read back as zero
         if (wr_hit(sfr_addr, ADDR_ENDPOINT_ENABLE, sfr_wr))
            endpoint_enable_control <= sfr_wdata & ENDPOINT_ENABLE_MASK;
         if (wr_hit(sfr_addr, ADDR_FUNCTION_ADDRESS, sfr_wr))
            function_address <= sfr_wdata;
      end
   end

   // Endpoint 0 status: toggle is software owned, the rest hardware owned
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         ep0_rx_status <= REG_RESET;
      else
      begin
         if (wr_hit(sfr_addr, ADDR_EP0_RX_STATUS, sfr_wr))
            ep0_rx_status[BIT_EP0_EXPECTED_TOGGLE] <= sfr_wdata[BIT_EP0_EXPECTED_TOGGLE];
         // A new token replaces the previous token-type bits
         if (tok_hit)
         begin
            ep0_rx_status[BIT_SETUP_DETECT] <= (tok_pid == PID_SETUP);
            ep0_rx_status[BIT_IN_DETECT] <= (tok_pid == PID_IN);
            ep0_rx_status[BIT_OUT_DETECT] <= (tok_pid == PID_OUT);
         end
         if (data_end_ep0 && toggle_match && !auto_status)
            ep0_rx_status[3:0] <= rx_count;
      end
   end

   // Byte counting and capture during an endpoint 0 data packet
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_count <= 4'h0;
         ep0_rx_data <= REG_RESET;
      end
      else if (state != ST_RX_DATA)
         rx_count <= 4'h0;
      else if (rx_byte_valid)
      begin
         // Saturate rather than wrap; low speed packets stay far below the cap
         if (rx_count != BYTE_COUNT_MAX)
            rx_count <= rx_count + 4'h1;
         // Auto-answered status stages carry no data for software
         if (!auto_status)
            ep0_rx_data <= rx_byte;
      end
   end

   // Control transfer tracking for the automatic status stage
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctl_setup <= 1'b0;
         ctl_read <= 1'b0;
      end
      else if (tok_ep0 && tok_pid == PID_SETUP)
      begin
         ctl_setup <= 1'b1;
         ctl_read <= 1'b0;
      end
      else if (tok_ep0 && tok_pid == PID_IN && ctl_setup)
         ctl_read <= 1'b1;
      else if (data_end_ep0 && auto_status)
      begin
         ctl_setup <= 1'b0;
         ctl_read <= 1'b0;
      end
   end

   // Transaction sequencer and handshake choice
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= ST_IDLE;
         resp_valid <= 1'b0;
         resp_kind <= RESP_ACK;
         resp_pid <= 4'h0;
         resp_len <= 4'h0;
         auto_status <= 1'b0;
         tx_ep12 <= 1'b0;
      end
      else
      begin
         resp_valid <= 1'b0;
         unique case (state)
            ST_IDLE:
            begin
               if (tok_ep0 && tok_pid == PID_IN)
               begin
                  resp_valid <= 1'b1;
                  tx_ep12 <= 1'b0;
                  if (ep0_tx_control[BIT_EP0_STALL])
                     resp_kind <= RESP_STALL;
                  else if (!ep0_tx_control[BIT_TX_ENABLE] || usb_interrupt_flags[BIT_EP0_TX_DONE_FLAG])
                     resp_kind <= RESP_NAK;
                  else
                  begin
                     resp_kind <= RESP_DATA;
                     resp_pid <= ep0_tx_control[BIT_TX_TOGGLE] ? PID_DATA1 : PID_DATA0;
                     resp_len <= ep0_tx_control[3:0];
                     state <= ST_TX_WAIT;
                  end
               end
               else if (tok_ep0 && (tok_pid == PID_OUT || tok_pid == PID_SETUP))
               begin
                  // Status-out of a control read is taken by hardware alone
                  auto_status <= (tok_pid == PID_OUT) && ctl_read
                     && endpoint_enable_control[BIT_AUTO_STATUS_OUT];
                  state <= ST_RX_DATA;
               end
               // Disabled endpoints stay silent
               else if (tok_ep12 && tok_pid == PID_IN && ep12_enabled)
               begin
                  resp_valid <= 1'b1;
                  tx_ep12 <= 1'b1;
                  if (ep12_stalled)
                     resp_kind <= RESP_STALL;
                  // Token for the endpoint not selected is NAKed too
                  else if (!ep12_tx_control[BIT_TX_ENABLE] || usb_interrupt_flags[BIT_EP12_TX_DONE_FLAG]
                     || (ep12_tx_control[BIT_EP12_SELECT] != (tok_endp == 4'h2)))
                     resp_kind <= RESP_NAK;
                  else
                  begin
                     resp_kind <= RESP_DATA;
                     resp_pid <= ep12_tx_control[BIT_TX_TOGGLE] ? PID_DATA1 : PID_DATA0;
                     resp_len <= ep12_tx_control[3:0];
                     state <= ST_TX_WAIT;
                  end
               end
               else if (tok_ep12 && tok_pid == PID_OUT && ep12_enabled && ep12_stalled)
               begin
                  resp_valid <= 1'b1;
                  resp_kind <= RESP_STALL;
               end
            end
            ST_RX_DATA:
            begin
               if (rx_pkt_end)
               begin
                  resp_valid <= 1'b1;
                  // Stall on endpoint 0 refuses OUT data, never SETUP or an auto status-out stage
                  if (ep0_tx_control[BIT_EP0_STALL] && !ep0_rx_status[BIT_SETUP_DETECT] && !auto_status)
                     resp_kind <= RESP_STALL;
                  else
                     resp_kind <= RESP_ACK;
                  auto_status <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            ST_TX_WAIT:
            begin
               // A new token means the host gave up on our data
               if (tx_ack || tok_valid)
                  state <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Data byte offered by the endpoint being served
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         tx_byte <= REG_RESET;
      else
         tx_byte <= tx_ep12 ? ep1_tx_data : ep0_tx_data;
   end

   // Logic clock enable and resume drive, registered for clean outputs
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         usb_clk_en <= 1'b0;
         force_resume <= 1'b0;
      end
      else
      begin
         usb_clk_en <= clk_link.tick;
         force_resume <= ep12_tx_control[BIT_FORCE_RESUME];
      end
   end

   // Read data, registered one cycle after the read strobe
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         sfr_rdata <= REG_RESET;
      else if (sfr_rd)
      begin
         unique case (sfr_addr)
            ADDR_CLOCK_DIVIDER: sfr_rdata <= usb_clock_divider;
            ADDR_EP1_TX_DATA: sfr_rdata <= ep1_tx_data;
            ADDR_EP0_TX_DATA: sfr_rdata <= ep0_tx_data;
            ADDR_INT_FLAGS: sfr_rdata <= usb_interrupt_flags;
            ADDR_INT_ENABLES: sfr_rdata <= usb_interrupt_enables;
            ADDR_EP0_TX_CONTROL: sfr_rdata <= ep0_tx_control;
            ADDR_EP12_TX_CONTROL: sfr_rdata <= ep12_tx_control;
            ADDR_ENDPOINT_ENABLE: sfr_rdata <= endpoint_enable_control;
            ADDR_EP0_RX_STATUS: sfr_rdata <= ep0_rx_status;
            ADDR_FUNCTION_ADDRESS: sfr_rdata <= function_address;
            ADDR_EP0_RX_DATA: sfr_rdata <= ep0_rx_data;
            default: sfr_rdata <= REG_RESET;
         endcase
      end
   end
endmodule : usbr_endpoint_regs

// ==== design/usbr_prescaler.sv ====
`timescale 1ns/10ps
module usbr_prescaler
   import usbr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Setting and tick
   usbr_clk_if.divider clk_port
);
   logic [8:0] count;
   logic [8:0] terminal;

   // One tick per 2 * (value + 1) cycles
   assign terminal = {clk_port.divide_value, 1'b1};

   // A new setting takes effect at once; a lower one can cut the current period short
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count <= 9'h000;
         clk_port.tick <= 1'b0;
      end
      else if (count >= terminal)
      begin
         count <= 9'h000;
         clk_port.tick <= 1'b1;
      end
      else
      begin
         count <= count + 9'h001;
         clk_port.tick <= 1'b0;
      end
   end
endmodule : usbr_prescaler

// ==== inc/usbr_clk_if.sv ====
`timescale 1ns/10ps
// Prescaler setting out, logic clock tick back
interface usbr_clk_if;
   logic [7:0] divide_value;
   logic tick;
   modport ctrl (output divide_value, input tick);
   modport divider (input divide_value, output tick);
endinterface : usbr_clk_if

// ==== inc/usbr_pkg.sv ====
package usbr_pkg;
   // Register addresses in special function register space
   localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'he1;
   localparam logic [7:0] ADDR_EP1_TX_DATA = 8'he6;
   localparam logic [7:0] ADDR_EP0_TX_DATA = 8'he7;
   localparam logic [7:0] ADDR_INT_FLAGS = 8'he8;
   localparam logic [7:0] ADDR_INT_ENABLES = 8'he9;
   localparam logic [7:0] ADDR_EP0_TX_CONTROL = 8'hea;
   localparam logic [7:0] ADDR_EP12_TX_CONTROL = 8'heb;
   localparam logic [7:0] ADDR_ENDPOINT_ENABLE = 8'hec;
   localparam logic [7:0] ADDR_EP0_RX_STATUS = 8'hed;
   localparam logic [7:0] ADDR_FUNCTION_ADDRESS = 8'hee;
   localparam logic [7:0] ADDR_EP0_RX_DATA = 8'hef;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Endpoint enable control fields
   localparam int BIT_AUTO_STATUS_OUT = 4;
   localparam int BIT_ENDPOINT2_ENABLE = 3;
   localparam int BIT_ENDPOINT1_ENABLE = 2;
   localparam int BIT_ENDPOINT2_FORCE_STALL = 1;
   localparam int BIT_ENDPOINT1_FORCE_STALL = 0;
   localparam logic [7:0] ENDPOINT_ENABLE_MASK = 8'h1f;
   // Endpoint 0 status fields
   localparam int BIT_EP0_EXPECTED_TOGGLE = 7;
   localparam int BIT_SETUP_DETECT = 6;
   localparam int BIT_IN_DETECT = 5;
   localparam int BIT_OUT_DETECT = 4;
   // Transmit control fields (endpoint 0 and endpoints 1/2 share a layout)
   localparam int BIT_TX_TOGGLE = 7;
   localparam int BIT_EP0_STALL = 6;
   localparam int BIT_EP12_SELECT = 6;
   localparam int BIT_TX_ENABLE = 5;
   localparam int BIT_FORCE_RESUME = 4;
   // Function address fields
   localparam int BIT_USB_FUNCTION_ENABLE = 7;
   // Interrupt flag fields
   localparam int BIT_SUSPEND_FLAG = 7;
   localparam int BIT_BUS_RESET_FLAG = 5;
   localparam int BIT_EP0_TX_DONE_FLAG = 4;
   localparam int BIT_EP0_RX_DONE_FLAG = 3;
   localparam int BIT_EP12_TX_DONE_FLAG = 2;
   localparam int BIT_EOP_FLAG = 1;
   localparam int BIT_RESUME_FLAG = 0;

   // Packet identifiers
   localparam logic [3:0] PID_OUT = 4'h1;
   localparam logic [3:0] PID_IN = 4'h9;
   localparam logic [3:0] PID_SETUP = 4'hd;
   localparam logic [3:0] PID_DATA0 = 4'h3;
   localparam logic [3:0] PID_DATA1 = 4'hb;
   localparam logic [3:0] BYTE_COUNT_MAX = 4'hf;

   // Answer kinds handed to the serial engine
   typedef enum logic [1:0] {RESP_ACK = 2'h0, RESP_NAK = 2'h1, RESP_STALL = 2'h2, RESP_DATA = 2'h3} usbr_resp_t;

   // Transaction sequencer, one-hot
   typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_RX_DATA = 3'h2, ST_TX_WAIT = 3'h4} usbr_state_t;
endpackage : usbr_pkg

// ==== tb/usb_low_speed_endpoint_regs_tb.sv ====
`timescale 1ns/10ps
// Self-checking bench for the endpoint register block
module usb_low_speed_endpoint_regs_tb
   import usbr_pkg::*;
;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q;} usbr_row_t;
   // Register port and idle bus events
   logic sys_clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, bus_ev = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
   // Link and answers
   logic tok_valid, rx_byte_valid, rx_pkt_end, tx_ack, usb_clk_en, resp_valid, force_resume;
   logic [3:0] tok_pid, tok_endp, rx_pid, resp_pid, resp_len;
   logic [6:0] tok_addr;
   logic [7:0] rx_byte, sfr_rdata, tx_byte, rd_val;
   usbr_resp_t resp_kind;
   int failures = 0, n_checks = 0, cyc = 0, n, k;
   // Write, read back
   usbr_row_t rows [9] = '{
      '{ADDR_CLOCK_DIVIDER, 8'h02, 8'h02},
      '{ADDR_EP1_TX_DATA, 8'h55, 8'h55},
      '{ADDR_EP0_TX_DATA, 8'haa, 8'haa},
      '{ADDR_INT_ENABLES, 8'h3c, 8'h3c},
      '{ADDR_ENDPOINT_ENABLE, 8'hff, 8'h1f},
      '{ADDR_EP0_RX_STATUS, 8'hff, 8'h80},
      '{ADDR_FUNCTION_ADDRESS, 8'h85, 8'h85},
      '{ADDR_EP0_RX_DATA, 8'h12, 8'h00},
      '{8'he0, 8'h77, 8'h00}};

   usbr_endpoint_regs i_usbr_endpoint_regs (.sys_clk, .rst_b, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
      .sfr_rdata, .tok_valid, .tok_pid, .tok_addr, .tok_endp, .rx_byte_valid, .rx_byte, .rx_pkt_end, .rx_pid,
      .tx_ack, .bus_reset(bus_ev), .bus_suspend(bus_ev), .bus_eop(bus_ev), .bus_resume(bus_ev), .usb_clk_en,
      .resp_valid, .resp_kind, .resp_pid, .resp_len, .tx_byte, .force_resume);
   usbr_host_model i_usbr_host_model (.sys_clk, .tok_valid, .tok_pid, .tok_addr, .tok_endp, .rx_byte_valid,
      .rx_byte, .rx_pkt_end, .rx_pid, .tx_ack);

   initial forever #2.5 sys_clk = ~sys_clk;
   // Hang guard, far above the run's length
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         tally_and_finish();
      end
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   // Register strobes last one edge; read data taken after that edge
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
      @(negedge sys_clk);
      sfr_wr = 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(negedge sys_clk);
      {sfr_rd, sfr_addr} = {1'b1, a};
      @(negedge sys_clk);
      sfr_rd = 1'b0;
      rd_val = sfr_rdata;
   endtask : rd
   // Answer pulse stands one cycle; looked at right after its cause
   task resp(input logic v, input usbr_resp_t kd);
      chk({7'h0, resp_valid}, {7'h0, v});
      if (v)
         chk({6'h0, resp_kind}, {6'h0, kd});
   endtask : resp
   task tk(input logic [3:0] pid, input logic [3:0] ep, input logic v, input usbr_resp_t kd);
      i_usbr_host_model.token(pid, 7'h05, ep);
      resp(v, kd);
   endtask : tk
   task tx_byte_is(input logic [7:0] b);
      @(posedge sys_clk);
      #1;
      chk(tx_byte, b);
      i_usbr_host_model.ack();
   endtask : tx_byte_is

   initial
   begin
      repeat (3) @(negedge sys_clk);
      rst_b = 1'b1;
      foreach (rows[i])
      begin
         rd(rows[i].a);
         chk(rd_val, 8'h00);
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         chk(rd_val, rows[i].q);
      end
      $display("register test done");
      // Tick spacing per supported divider, measured after two settling ticks
      for (int d = 0; d < 3; d++)
      begin
         wr(ADDR_CLOCK_DIVIDER, 8'(d));
         n = 0;
         k = 0;
         while (k < 3 && n < 100)
         begin
            @(negedge sys_clk);
            n++;
            k += int'(usb_clk_en);
            if (usb_clk_en && k < 3) n = 0;
         end
         chk(8'(n), 8'(2 * (d + 1)));
      end
      $display("prescaler test done");
      // Setup with three bytes, then a toggle mismatch, then a control read
      tk(PID_SETUP, 4'h0, 1'b0, RESP_ACK);
      rd(ADDR_EP0_RX_STATUS);
      chk(rd_val & 8'h40, 8'h40);
      i_usbr_host_model.data(PID_DATA1, 3, 8'h31);
      resp(1'b1, RESP_ACK);
      rd(ADDR_EP0_RX_STATUS);
      chk(rd_val & 8'h0f, 8'h03);
      rd(ADDR_EP0_RX_DATA);
      chk(rd_val, 8'h33);
      tk(PID_OUT, 4'h0, 1'b0, RESP_ACK);
      i_usbr_host_model.data(PID_DATA0, 2, 8'h51);
      resp(1'b1, RESP_ACK);
      rd(ADDR_EP0_RX_STATUS);
      chk(rd_val & 8'h1f, 8'h13);
      wr(ADDR_EP0_TX_CONTROL, 8'h25);
      tk(PID_IN, 4'h0, 1'b1, RESP_DATA);
      chk({resp_pid, resp_len}, {PID_DATA0, 4'h5});
      tx_byte_is(8'haa);
      rd(ADDR_EP0_RX_STATUS);
      chk(rd_val & 8'h20, 8'h20);
      // Zero-length status stage answered without touching the count
      tk(PID_OUT, 4'h0, 1'b0, RESP_ACK);
      i_usbr_host_model.data(PID_DATA1, 0, 8'h00);
      resp(1'b1, RESP_ACK);
      rd(ADDR_EP0_RX_STATUS);
      chk(rd_val & 8'h1f, 8'h13);
      $display("endpoint 0 test done");
      tk(PID_IN, 4'h1, 1'b1, RESP_STALL);
      tk(PID_IN, 4'h2, 1'b1, RESP_STALL);
      tk(PID_OUT, 4'h1, 1'b1, RESP_STALL);
      wr(ADDR_ENDPOINT_ENABLE, 8'h0c);
      tk(PID_IN, 4'h1, 1'b1, RESP_NAK);
      wr(ADDR_EP12_TX_CONTROL, 8'h23);
      tk(PID_IN, 4'h1, 1'b1, RESP_DATA);
      chk({resp_pid, resp_len}, {PID_DATA0, 4'h3});
      tx_byte_is(8'h55);
      tk(PID_IN, 4'h1, 1'b1, RESP_NAK);
      tk(PID_IN, 4'h2, 1'b1, RESP_NAK);
      wr(ADDR_ENDPOINT_ENABLE, 8'h00);
      tk(PID_IN, 4'h1, 1'b0, RESP_ACK);
      tk(PID_IN, 4'h2, 1'b0, RESP_ACK);
      $display("endpoint 1 and 2 test done");
      i_usbr_host_model.token(PID_IN, 7'h06, 4'h0);
      resp(1'b0, RESP_ACK);
      wr(ADDR_FUNCTION_ADDRESS, 8'h05);
      tk(PID_IN, 4'h0, 1'b0, RESP_ACK);
      $display("address test done");
      // Reset in mid-run clears the settings again
      wr(ADDR_ENDPOINT_ENABLE, 8'h1f);
      rst_b = 1'b0;
      repeat (3) @(negedge sys_clk);
      rst_b = 1'b1;
      rd(ADDR_EP0_RX_STATUS);
      chk(rd_val, 8'h00);
      rd(ADDR_ENDPOINT_ENABLE);
      chk(rd_val, 8'h00);
      $display("second reset test done");
      tally_and_finish();
   end
endmodule : usb_low_speed_endpoint_regs_tb

// ==== tb/usbr_endpoint_regs_chk.sv ====
`timescale 1ns/10ps
// Port-level watcher for the endpoint register block
module usbr_endpoint_regs_chk
   import usbr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // Link and answers
   input wire logic tok_valid,
   input wire logic [3:0] tok_pid,
   input wire logic [6:0] tok_addr,
   input wire logic [3:0] tok_endp,
   input wire logic rx_pkt_end,
   input wire logic usb_clk_en,
   input wire logic resp_valid,
   input wire usbr_resp_t resp_kind
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic [7:0] ec, fa, e1;
   logic hit, in1, in2;
   // Shadow settings the answers depend on
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         {ec, fa, e1} <= '0;
      else if (sfr_wr)
      begin
         if (sfr_addr == ADDR_ENDPOINT_ENABLE) ec <= sfr_wdata & ENDPOINT_ENABLE_MASK;
         if (sfr_addr == ADDR_FUNCTION_ADDRESS) fa <= sfr_wdata;
         if (sfr_addr == ADDR_EP12_TX_CONTROL) e1 <= sfr_wdata;
      end
   end
   // Tokens addressed to this function
   assign hit = tok_valid && fa[7] && tok_addr == fa[6:0];
   assign in1 = hit && tok_pid == PID_IN && tok_endp == 4'h1;
   assign in2 = hit && tok_pid == PID_IN && tok_endp == 4'h2;
   sequence s_setup_tok;
      hit && tok_pid == PID_SETUP;
   endsequence
   sequence s_status_rd;
      sfr_rd && sfr_addr == ADDR_EP0_RX_STATUS;
   endsequence
   addr_gate_a: assert property (tok_valid && !hit |=> !resp_valid)
      else $error("answer to a foreign token");
   resp_cause_a: assert property (resp_valid |-> $past(tok_valid) || $past(rx_pkt_end))
      else $error("answer without a cause");
   ep1_stall_a: assert property (in1 && ec[2] && ec[0] |=> resp_valid && resp_kind == RESP_STALL)
      else $error("endpoint 1 not stalled");
   ep2_stall_a: assert property (in2 && ec[3] && ec[1] |=> resp_valid && resp_kind == RESP_STALL)
      else $error("endpoint 2 not stalled");
   ep1_off_a: assert property (in1 && !ec[2] |=> !resp_valid)
      else $error("disabled endpoint 1 answered");
   ep2_off_a: assert property (in2 && !ec[3] |=> !resp_valid)
      else $error("disabled endpoint 2 answered");
   ep1_nak_a: assert property (in1 && ec[2] && !ec[0] && !e1[5] |=> resp_valid && resp_kind == RESP_NAK)
      else $error("idle endpoint 1 did not refuse");
   ctl_readback_a: assert property (sfr_rd && sfr_addr == ADDR_ENDPOINT_ENABLE |=> sfr_rdata == {3'h0, ec[4:0]})
      else $error("control register readback wrong");
   setup_seen_a: assert property (s_setup_tok ##2 s_status_rd |=> sfr_rdata[BIT_SETUP_DETECT])
      else $error("setup detect missing");
   tick_gap_a: assert property (usb_clk_en |=> !usb_clk_en)
      else $error("logic clock ticks too close");
endmodule : usbr_endpoint_regs_chk

bind usbr_endpoint_regs usbr_endpoint_regs_chk i_usbr_endpoint_regs_chk (.*);

// ==== tb/usbr_host_model.sv ====
`timescale 1ns/10ps
// Host controller side: tokens, data packets and handshakes
module usbr_host_model
   import usbr_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Token
   output logic tok_valid,
   output logic [3:0] tok_pid,
   output logic [6:0] tok_addr,
   output logic [3:0] tok_endp,
   // Data packet and handshake
   output logic rx_byte_valid,
   output logic [7:0] rx_byte,
   output logic rx_pkt_end,
   output logic [3:0] rx_pid,
   output logic tx_ack
);
   // Idle link; released fields show inverted values
   initial
   begin
      {tok_valid, rx_byte_valid, rx_pkt_end, tx_ack} = 4'h0;
      {tok_pid, tok_addr, tok_endp, rx_byte, rx_pid} = '0;
   end
   // One token, strobe for a single cycle
   task token(input logic [3:0] pid, input logic [6:0] a, input logic [3:0] ep);
      @(negedge sys_clk);
      {tok_valid, tok_pid, tok_addr, tok_endp} = {1'b1, pid, a, ep};
      @(negedge sys_clk);
      {tok_valid, tok_pid, tok_addr, tok_endp} = {1'b0, ~pid, ~a, ~ep};
   endtask : token
   // Data packet of n counting bytes, then its end marker
   task data(input logic [3:0] pid, input int n, input logic [7:0] b0);
      for (int i = 0; i < n; i++)
      begin
         @(negedge sys_clk);
         {rx_byte_valid, rx_byte} = {1'b1, b0 + 8'(i)};
      end
      @(negedge sys_clk);
      {rx_byte_valid, rx_byte, rx_pkt_end, rx_pid} = {1'b0, ~rx_byte, 1'b1, pid};
      @(negedge sys_clk);
      {rx_pkt_end, rx_pid} = {1'b0, ~pid};
   endtask : data
   // Host accepts our data packet
   task ack();
      @(negedge sys_clk);
      tx_ack = 1'b1;
      @(negedge sys_clk);
      tx_ack = 1'b0;
   endtask : ack
endmodule : usbr_host_model
